// ===== design/io_expander_smbus_manager.sv
// io_expander_smbus_manager: keeps up to four smbus i/o expanders in step with the core view
// assumes config inputs come from ref_clk logic; smb_clk runs free at four times the bit rate
// Contract
// - link expander config writes link-up to register 2, then activity to register 3.
// - link expander config then writes zero to registers 4 and 5.
// - link expander config ends writing all-output directions to registers 6 and 7.
// - enabled expander whose pins differ from the internal view gets a fixing transaction.
// - hot reset restoring hot-plug defaults leads to writes matching the new state.
// - outputs of one expander are written at most once per 40 ms.
// - an asserted expander interrupt causes a read of its input registers.
// - inputs of one expander are read at most once per 40 ms.
// - pending expander transactions are served round robin, equal latency for all.
// - errors in expander transactions are recorded in the smbus status bits.
// - select field picks the debug expander; state field shows its inputs and outputs.
// - reload bit causes write and read to selected expander, refreshing state field.
// - in test mode the selected expander's outputs come from the state data field, not the core.
// - in test mode a write changing an output bit triggers an update.
// - addresses loaded during eeprom init are configured once normal operation starts.
// - init output values are those present when each transaction starts.
// - every hot-plug output change, including from resets, produces a transaction.
// - entering fundamental reset issues no transaction that alters expander outputs.
// - expander zero maps port 2 inputs/outputs to bits 0-7, port 4 to 8-15.
// - link and activity led pins are active low; hot-plug pins are not inverted.
// - writing an address configures that expander, disabled ports' outputs negated.
// - no expander transaction starts before eeprom initialisation has finished.
`timescale 1ns/1ns
module io_expander_smbus_manager
  import expander_pkg::*;
#(
  parameter int UPD_CYC = UPDATE_CYC
) (
  // clocks and reset
  input  wire logic                           ref_clk,
  input  wire logic                           smb_clk,
  input  wire logic                           rst_n,
  // initialisation and addressing
  input  wire logic                           eeprom_done,
  input  wire logic [NUM_EXP-1:0][6:0]        expander_address_field,
  input  wire logic [NUM_EXP-1:0]             addr_we,
  // core view of expander outputs, logical polarity
  input  wire logic [NUM_EXP-1:0][15:0]       core_out,
  input  wire logic [NUM_EXP-1:0][1:0]        half_off,
  // debug register fields
  input  wire logic [SLOT_W-1:0]              dbg_sel,
  input  wire logic [15:0]                    dbg_data_wdata,
  input  wire logic                           dbg_data_we,
  input  wire logic                           reload_request_bit,
  input  wire logic                           expander_test_mode_bit,
  output logic      [15:0]                    expander_state_field,
  // status
  input  wire logic                           status_clr,
  output logic      [1:0]                     smbus_status_register,
  // expander interrupt inputs, active low, asynchronous
  input  wire logic [NUM_EXP-1:0]             exp_int_n,
  // master smbus pins, open drain
  input  wire logic                           scl_i,
  output logic                                scl_o,
  output logic                                scl_oe,
  input  wire logic                           sda_i,
  output logic                                sda_o,
  output logic                                sda_oe
);

  localparam int TW = $clog2(UPD_CYC + 1);
  localparam logic [TW-1:0] TMR_LOAD = TW'(UPD_CYC - 1);

  // builds the byte access for one step of a job
  function automatic smb_req_t mk_req(input logic [6:0] a, input job_t j,
                                      input logic [2:0] s, input logic [15:0] w,
                                      input logic [15:0] m);
    smb_req_t r;
    r.addr   = a;
    r.rd     = (j == J_RD);
    r.regnum = (j == J_RD ? REG_IN_LO : REG_OUT_LO) + {5'h00, s};
    unique case (r.regnum)
      REG_OUT_LO: r.data = w[7:0];
      REG_OUT_HI: r.data = w[15:8];
      REG_POL_LO: r.data = POL_NONE;
      REG_POL_HI: r.data = POL_NONE;
      REG_DIR_LO: r.data = ~m[7:0];
      REG_DIR_HI: r.data = ~m[15:8];
      default:    r.data = 8'hff;
    endcase
    return r;
  endfunction

  // byte sent on the wire for a given position in the access
  function automatic logic [7:0] byte_of(input smb_req_t r, input logic [1:0] b);
    logic [7:0] v;
    unique case (b)
      2'h0:    v = {r.addr, 1'b0};
      2'h1:    v = r.regnum;
      2'h2:    v = r.rd ? {r.addr, 1'b1} : r.data;
      default: v = 8'hff;
    endcase
    return v;
  endfunction

  // core domain state
  core_st_t            st;
  job_t                job, pick_job;
  logic [SLOT_W-1:0]   cur, rr_ptr, pick;
  logic [2:0]          step;
  logic [15:0]         snap;
  smb_req_t            req_q;
  logic                req_tgl, ack_s1, ack_s2, ack_seen;
  logic [NUM_EXP-1:0]  int_s1, int_s2;
  logic [NUM_EXP-1:0]  cfg_pend, cfg_done, rd_force, wr_force;
  logic [NUM_EXP-1:0]  c_need, w_need, r_need;
  logic [15:0]         sent_q [NUM_EXP];
  logic [15:0]         in_q   [NUM_EXP];
  logic [15:0]         want   [NUM_EXP];
  logic [TW-1:0]       wr_tmr [NUM_EXP];
  logic [TW-1:0]       rd_tmr [NUM_EXP];
  logic [15:0]         dbg_data_q;
  logic                found, start_ev, ack_new, step_ok, job_ok, last_step;

  // link domain state
  link_st_t            l_st;
  smb_rsp_t            rsp_q;
  logic [1:0]          q;
  logic [3:0]          bit_i;
  logic [1:0]          byte_i;
  logic [7:0]          sh;
  logic                got_nack, ack_tgl, req_s1, req_s2, req_seen;
  logic                scl_s1, scl_s2, sda_s1, sda_s2, rx;

  // interrupt pins are asynchronous: two flops before any use
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_s1 <= '1;
      int_s2 <= '1;
    end else begin
      int_s1 <= exp_int_n;
      int_s2 <= int_s1;
    end
  end

  // acknowledge toggle from the link domain
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  // desired pin values per slot, masked to the output bits
  always_comb begin
    for (int i = 0; i < NUM_EXP; i++) begin
      want[i] = core_out[i] ^ INV_MASK[i]; // leds driven low when lit
      if (half_off[i][0]) want[i][7:0] = NEG_VAL[i][7:0];
      if (half_off[i][1]) want[i][15:8] = NEG_VAL[i][15:8];
      if (expander_test_mode_bit && dbg_sel == SLOT_W'(i)) begin
        want[i] = dbg_data_q; // core values ignored
      end
      want[i] = want[i] & OUT_MASK[i];
    end
  end

  // what each slot is waiting for; timers gate every kind of access
  always_comb begin
    for (int i = 0; i < NUM_EXP; i++) begin
      c_need[i] = cfg_pend[i] && wr_tmr[i] == '0;
      // any mismatch of pins and internal view, resets included
      w_need[i] = cfg_done[i] && !cfg_pend[i] && wr_tmr[i] == '0
                  && (wr_force[i] || want[i] != sent_q[i]);
      r_need[i] = cfg_done[i] && !cfg_pend[i] && HAS_IN[i] && rd_tmr[i] == '0
                  && (rd_force[i] || !int_s2[i]);
    end
  end

  // round robin pick starting after the last slot served
  always_comb begin
    logic [SLOT_W-1:0] idx;
    idx      = rr_ptr;
    pick     = rr_ptr;
    pick_job = J_RD;
    found    = 1'b0;
    for (int k = NUM_EXP - 1; k >= 0; k--) begin
      idx = rr_ptr + SLOT_W'(k); // wraps since the slot count is a power of two
      if (c_need[idx] || w_need[idx] || r_need[idx]) begin
        pick  = idx; // nearest pending slot wins
        found = 1'b1;
        pick_job = c_need[idx] ? J_CFG : (w_need[idx] ? J_WR : J_RD);
      end
    end
  end

  assign start_ev  = (st == C_IDLE) && found;
  assign ack_new   = (st == C_WAIT) && (ack_s2 != ack_seen);
  assign last_step = step == (job == J_CFG ? CFG_LAST : XFER_LAST);
  assign step_ok   = ack_new && !rsp_q.nack;
  assign job_ok    = step_ok && last_step;

  // job sequencer: one byte access at a time through the toggle handshake
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st       <= C_BOOT;
      job      <= J_RD;
      cur      <= '0;
      rr_ptr   <= '0;
      step     <= 3'h0;
      snap     <= 16'h0000;
      req_q    <= '0;
      req_tgl  <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      unique case (st)
        C_BOOT: begin
          if (eeprom_done) st <= C_IDLE; // bus belongs to the loader until then
        end
        C_IDLE: begin
          if (found) begin
            cur    <= pick;
            job    <= pick_job;
            rr_ptr <= pick + SLOT_W'(1);
            step   <= 3'h0;
            snap   <= want[pick];
            st     <= C_ISSUE;
          end
        end
        C_ISSUE: begin
          // data taken from snap, sampled when the job started, not when the slot first became pending
          req_q   <= mk_req(expander_address_field[cur], job, step, snap, OUT_MASK[cur]);
          req_tgl <= ~req_tgl;
          st      <= C_WAIT;
        end
        C_WAIT: begin
          if (ack_new) begin
            ack_seen <= ack_s2;
            if (rsp_q.nack || last_step) begin
              st <= C_IDLE; // an error abandons the job; the timer paces the retry
            end else begin
              step <= step + 3'h1; // next register in order: 2..7 for config, 2..3 for a write, 0..1 for a read
              st   <= C_ISSUE;
            end
          end
        end
      endcase
    end
  end

  // per-slot update timers, one per direction
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_EXP; i++) begin
        wr_tmr[i] <= '0;
        rd_tmr[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_EXP; i++) begin
        if (start_ev && pick == SLOT_W'(i) && pick_job != J_RD) begin
          wr_tmr[i] <= TMR_LOAD;
        end else if (wr_tmr[i] != '0) begin
          wr_tmr[i] <= wr_tmr[i] - TW'(1);
        end
        if (start_ev && pick == SLOT_W'(i) && pick_job == J_RD) begin
          rd_tmr[i] <= TMR_LOAD; // debounce window for the inputs
        end else if (rd_tmr[i] != '0) begin
          rd_tmr[i] <= rd_tmr[i] - TW'(1);
        end
      end
    end
  end

  // slot flags; a setting event in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_pend <= '0;
      cfg_done <= '0;
      rd_force <= '0;
      wr_force <= '0;
    end else begin
      for (int i = 0; i < NUM_EXP; i++) begin
        if (addr_we[i]) begin
          cfg_pend[i] <= 1'b1;
          cfg_done[i] <= 1'b0;
        end else if (job_ok && cur == SLOT_W'(i) && job == J_CFG) begin
          cfg_pend[i] <= 1'b0;
          cfg_done[i] <= 1'b1;
        end
        if ((job_ok && cur == SLOT_W'(i) && job == J_CFG && HAS_IN[i])
            || (reload_request_bit && dbg_sel == SLOT_W'(i))) begin
          rd_force[i] <= 1'b1;
        end else if (start_ev && pick == SLOT_W'(i) && pick_job == J_RD) begin
          rd_force[i] <= 1'b0;
        end
        if (reload_request_bit && dbg_sel == SLOT_W'(i)) begin
          wr_force[i] <= 1'b1;
        end else if (start_ev && pick == SLOT_W'(i) && pick_job != J_RD) begin
          wr_force[i] <= 1'b0;
        end
      end
    end
  end

  // record what the pins hold: outputs after a write job, inputs after each read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_EXP; i++) begin
        sent_q[i] <= 16'h0000;
        in_q[i]   <= 16'h0000;
      end
    end else begin
      if (job_ok && job != J_RD) sent_q[cur] <= snap;
      if (step_ok && job == J_RD) begin
        if (step == 3'h0) in_q[cur][7:0] <= rsp_q.data;
        else in_q[cur][15:8] <= rsp_q.data;
      end
    end
  end

  // error bits: bit 0 when byte 0 or byte 2 is refused, bit 1 when the register byte is refused
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      smbus_status_register <= STATUS_RST;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (ack_new && rsp_q.nack && (rsp_q.addr_nack == (b == 0))) begin
          smbus_status_register[b] <= 1'b1;
        end else if (status_clr) begin
          smbus_status_register[b] <= 1'b0;
        end
      end
    end
  end

  // debug data field and the view shown for the selected slot
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_data_q           <= DBG_DATA_RST;
      expander_state_field <= DBG_DATA_RST;
    end else begin
      if (dbg_data_we) dbg_data_q <= dbg_data_wdata;
      expander_state_field <= (sent_q[dbg_sel] & OUT_MASK[dbg_sel])
                              | (in_q[dbg_sel] & ~OUT_MASK[dbg_sel]);
    end
  end

  // link domain: request toggle and bus pins through two flops each
  always_ff @(posedge smb_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
    end
  end

  // phase counter; holds in the sample phase while a slave stretches the clock
  always_ff @(posedge smb_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= PH_DRIVE;
    end else if (l_st == L_IDLE) begin
      q <= PH_DRIVE;
    end else if (!(q == PH_SAMP && !scl_s2)) begin
      q <= q + 2'h1;
    end
  end

  assign rx = req_q.rd && byte_i == 2'h3;

  // bit engine: start, bytes with acknowledge, repeated start, stop
  always_ff @(posedge smb_clk or negedge rst_n) begin
    if (!rst_n) begin
      // reset drops the bus at once; no new output write can complete
      l_st     <= L_IDLE;
      bit_i    <= 4'h0;
      byte_i   <= 2'h0;
      sh       <= 8'h00;
      got_nack <= 1'b0;
      rsp_q    <= '0;
      ack_tgl  <= 1'b0;
      req_seen <= 1'b0;
      scl_o    <= 1'b0;
      scl_oe   <= 1'b0;
      sda_o    <= 1'b0;
      sda_oe   <= 1'b0;
    end else begin
      unique case (l_st)
        L_IDLE: begin
          if (req_s2 != req_seen) begin
            req_seen       <= req_s2;
            byte_i         <= 2'h0;
            rsp_q.nack     <= 1'b0;
            rsp_q.addr_nack <= 1'b0;
            l_st           <= L_START;
          end
        end
        L_START: begin
          unique case (q)
            PH_DRIVE: sda_oe <= 1'b0;
            PH_RISE:  scl_oe <= 1'b0;
            PH_SAMP:  if (scl_s2) sda_oe <= 1'b1;
            PH_FALL: begin
              scl_oe <= 1'b1;
              sh     <= byte_of(req_q, byte_i);
              bit_i  <= 4'h0;
              l_st   <= L_BIT;
            end
          endcase
        end
        L_BIT: begin
          unique case (q)
            PH_DRIVE: sda_oe <= bit_i != ACK_BIT && !rx && !sh[7]; // master nacks a read
            PH_RISE:  scl_oe <= 1'b0;
            PH_SAMP: begin
              if (scl_s2 && bit_i == ACK_BIT) got_nack <= sda_s2 && !rx;
              else if (scl_s2) sh <= {sh[6:0], sda_s2};
            end
            PH_FALL: begin
              scl_oe <= 1'b1;
              if (bit_i != ACK_BIT) begin
                bit_i <= bit_i + 4'h1;
              end else if (got_nack) begin
                rsp_q.nack      <= 1'b1;
                rsp_q.addr_nack <= byte_i == 2'h0 || byte_i == 2'h2;
                l_st            <= L_STOP;
              end else if (rx) begin
                rsp_q.data <= sh;
                l_st       <= L_STOP;
              end else if (!req_q.rd && byte_i == 2'h2) begin
                l_st <= L_STOP;
              end else if (req_q.rd && byte_i == 2'h1) begin
                byte_i <= 2'h2; // repeated start, then address with read bit
                l_st   <= L_START;
              end else begin
                byte_i <= byte_i + 2'h1;
                sh     <= byte_of(req_q, byte_i + 2'h1);
                bit_i  <= 4'h0;
              end
            end
          endcase
        end
        L_STOP: begin
          unique case (q)
            PH_DRIVE: sda_oe <= 1'b1;
            PH_RISE:  scl_oe <= 1'b0;
            PH_SAMP:  if (scl_s2) sda_oe <= 1'b0;
            PH_FALL: begin
              ack_tgl <= ~ack_tgl; // answer stays stable until the next request
              l_st    <= L_IDLE;
            end
          endcase
        end
      endcase
    end
  end

endmodule

// ===== shared/expander_pkg.sv
// expander_pkg: constants, types and pin maps for the smbus i/o expander manager
// assumes a 100 mhz core clock and a free-running clock at four times the bit rate for the smbus engine
package expander_pkg;

  // expander slots; slot 3 carries expander four (link status leds)
  localparam int NUM_EXP = 4;
  localparam int SLOT_W  = 2;

  // update period: 40 ms at the core clock rate
  localparam int UPDATE_MS   = 40;
  localparam int REF_CLK_KHZ = 100000;
  localparam int UPDATE_CYC  = UPDATE_MS * REF_CLK_KHZ;

  // expander register numbers
  localparam logic [7:0] REG_IN_LO  = 8'h00;
  localparam logic [7:0] REG_OUT_LO = 8'h02;
  localparam logic [7:0] REG_OUT_HI = 8'h03;
  localparam logic [7:0] REG_POL_LO = 8'h04;
  localparam logic [7:0] REG_POL_HI = 8'h05;
  localparam logic [7:0] REG_DIR_LO = 8'h06;
  localparam logic [7:0] REG_DIR_HI = 8'h07;
  localparam logic [7:0] POL_NONE   = 8'h00;

  // step counts: config is six writes, output update and input read are two
  localparam logic [2:0] CFG_LAST  = 3'h5;
  localparam logic [2:0] XFER_LAST = 3'h1;

  // bit engine: four phases per bit, bit 8 is the acknowledge slot
  localparam logic [3:0] ACK_BIT  = 4'h8;
  localparam logic [1:0] PH_DRIVE = 2'h0;
  localparam logic [1:0] PH_RISE  = 2'h1;
  localparam logic [1:0] PH_SAMP  = 2'h2;
  localparam logic [1:0] PH_FALL  = 2'h3;

  // per-slot pin maps: outputs, inverted (active-low led) bits, negated values
  localparam logic [15:0] OUT_MASK [NUM_EXP] = '{16'hf0f0, 16'hf0f0, 16'hc0f0, 16'hffff};
  localparam logic [15:0] INV_MASK [NUM_EXP] = '{16'h0000, 16'h0000, 16'h0000, 16'hffff};
  localparam logic [15:0] NEG_VAL  [NUM_EXP] = '{16'h3030, 16'h3030, 16'h0000, 16'hffff};
  localparam logic [NUM_EXP-1:0] HAS_IN = 4'h7;

  // values after reset
  localparam logic [15:0] DBG_DATA_RST = 16'h0000;
  localparam logic [1:0]  STATUS_RST   = 2'h0;

  typedef enum logic [1:0] {C_BOOT = 2'b00, C_IDLE = 2'b01, C_ISSUE = 2'b10, C_WAIT = 2'b11}
    core_st_t;
  typedef enum logic [1:0] {J_CFG = 2'b00, J_WR = 2'b01, J_RD = 2'b10} job_t;
  typedef enum logic [1:0] {L_IDLE = 2'b00, L_START = 2'b01, L_BIT = 2'b10, L_STOP = 2'b11}
    link_st_t;

  // one byte access handed from the core domain to the bit engine
  typedef struct packed {
    logic [6:0] addr;
    logic       rd;
    logic [7:0] regnum;
    logic [7:0] data;
  } smb_req_t;

  // answer handed back from the bit engine
  typedef struct packed {
    logic [7:0] data;
    logic       nack;
    logic       addr_nack;
  } smb_rsp_t;

endpackage

// ===== tb/exp_mgr_chk.sv
// checker: bus idling, open-drain drive and status stickiness at the manager's ports
// assumes it is bound onto io_expander_smbus_manager, all properties on ref_clk
`timescale 1ns/1ns
module exp_mgr_chk
  import expander_pkg::*;
(
  // watched ports
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        eeprom_done,
  input wire logic        status_clr,
  input wire logic [1:0]  smbus_status_register,
  input wire logic [15:0] expander_state_field,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_o,
  input wire logic        sda_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // the shared bus belongs to the eeprom loader until it is done
  a_quiet_before_load: assert property (!eeprom_done |-> !scl_oe && !sda_oe)
    else $error("bus driven before load done");
  a_quiet_release: assert property ($rose(rst_n) |-> !scl_oe && !sda_oe
    && smbus_status_register == STATUS_RST && expander_state_field == DBG_DATA_RST)
    else $error("outputs not idle after reset");
  // open drain: the pins are only ever pulled low
  a_sda_low_only: assert property (sda_o == 1'b0)
    else $error("sda driven high");
  a_scl_low_only: assert property (scl_o == 1'b0)
    else $error("scl driven high");
  // status bits are sticky until cleared
  a_addr_err_sticky: assert property ($fell(smbus_status_register[0]) |-> $past(status_clr))
    else $error("address error bit dropped");
  a_data_err_sticky: assert property ($fell(smbus_status_register[1]) |-> $past(status_clr))
    else $error("data error bit dropped");
  a_addr_err_cause: assert property ($rose(smbus_status_register[0]) |-> eeprom_done)
    else $error("address error without bus use");
  a_data_err_cause: assert property ($rose(smbus_status_register[1]) |-> eeprom_done)
    else $error("data error without bus use");
endmodule

bind io_expander_smbus_manager exp_mgr_chk i_exp_mgr_chk (.ref_clk, .rst_n, .eeprom_done,
  .status_clr, .smbus_status_register, .expander_state_field, .scl_o, .scl_oe, .sda_o, .sda_oe);

// ===== tb/exp_model.sv
// expander model: smbus slave with register pointer, input port and interrupt
// assumes the bench resolves both open-drain wires with pull-ups
`timescale 1ns/1ns
module exp_model #(
  parameter logic [6:0] ADDR = 7'h21
) (
  // bus and pins
  input  wire logic        scl,
  input  wire logic        sda,
  input  wire logic [15:0] pins_in,
  output logic             sda_pull,
  output logic             int_n,
  // write notes for the bench
  output logic             wr_stb,
  output logic [7:0]       wr_reg,
  output logic [7:0]       wr_dat
);
  logic [7:0]  sh, ptr, rb;
  logic [15:0] seen = 16'h0000;
  logic        rd = 1'b0, act = 1'b0;
  int          bits, nb;
  initial sda_pull = 1'b0;
  initial wr_stb = 1'b0;
  // interrupt stands while an input differs from its last read value
  assign int_n = (pins_in & 16'h0f0f) == (seen & 16'h0f0f);
  // start or repeated start restarts the count; stop ends the frame
  always @(negedge sda) if (scl) begin
    bits = 0;
    nb = 0;
    act = 1'b1;
  end
  always @(posedge sda) if (scl) act = 1'b0;
  always @(posedge scl) if (act) begin
    if (bits < 8) sh = {sh[6:0], sda};
    bits++;
  end
  // ack and read data change only while scl is low
  always @(negedge scl) if (act) begin
    sda_pull = 1'b0;
    wr_stb = 1'b0;
    rb = ptr[0] ? pins_in[15:8] : pins_in[7:0];
    if (bits == 8 && nb == 0) begin
      rd = sh[0];
      act = sh[7:1] == ADDR;
      sda_pull = act;
    end else if (bits == 8 && !rd) begin
      sda_pull = 1'b1;
      if (nb == 1) ptr = sh;
      else {wr_reg, wr_dat, wr_stb} = {ptr, sh, 1'b1};
    end else if (bits == 8) begin
      if (ptr[0]) seen[15:8] = rb;
      else seen[7:0] = rb;
    end
    if (bits == 8) nb++;
    if (bits == 9) bits = 0;
    if (rd && nb == 1 && bits < 8) sda_pull = !rb[7 - bits]; // one byte, then free the line
  end
endmodule

// ===== tb/io_expander_smbus_manager_tb.sv
// bench: one expander model on the bus serving the link slot and slot zero
// assumes a short update period; slot one carries an address nobody answers
`timescale 1ns/1ns
module io_expander_smbus_manager_tb
  import expander_pkg::*;
;
  localparam int         UPD = 6000;
  localparam logic [6:0] ADR = 7'h21;
  logic                     ref_clk = 0, smb_clk = 0, rst_n = 0, eeprom_done = 0;
  logic [NUM_EXP-1:0][6:0]  addr = {ADR, 7'h00, 7'h55, ADR};
  logic [NUM_EXP-1:0]       addr_we = '0;
  logic [NUM_EXP-1:0][15:0] core_out = '0;
  logic [NUM_EXP-1:0][1:0]  half_off = '0;
  logic [15:0]              state, pins = 16'h0f0f, dwd = 16'h0000;
  logic                     reload = 0, status_clr = 0, pull, int_n, wstb, tm = 0, dwe = 0;
  logic [1:0]               status;
  logic                     scl_o, scl_oe, sda_o, sda_oe;
  logic [7:0]               wreg, wdat;
  logic [23:0]              expq[$], e;
  time                      t_lo[$];
  int                       n_errors = 0, checked = 0;
  always #5 ref_clk = ~ref_clk;
  // link clock, three ref_clk periods long, offset so its edges never meet a ref_clk edge
  initial begin
    #3;
    forever #15 smb_clk = ~smb_clk;
  end
  io_expander_smbus_manager #(.UPD_CYC(UPD)) i_io_expander_smbus_manager (.ref_clk, .smb_clk,
    .rst_n, .eeprom_done, .expander_address_field(addr), .addr_we, .core_out, .half_off,
    .dbg_sel(2'h0), .dbg_data_wdata(dwd), .dbg_data_we(dwe), .reload_request_bit(reload),
    .expander_test_mode_bit(tm), .expander_state_field(state), .status_clr,
    .smbus_status_register(status), .exp_int_n({3'h7, int_n}), .scl_i(~scl_oe),
    .scl_o, .scl_oe, .sda_i(~(sda_oe | pull)), .sda_o, .sda_oe);
  exp_model #(.ADDR(ADR)) i_exp_model (.scl(~scl_oe), .sda(~(sda_oe | pull)), .pins_in(pins),
    .sda_pull(pull), .int_n, .wr_stb(wstb), .wr_reg(wreg), .wr_dat(wdat));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic complete_run();
    $display("errors %0d checked %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // expected pin values: leds inverted, negated halves forced
  function automatic logic [15:0] pinv(input int s);
    logic [15:0] v;
    v = core_out[s] ^ INV_MASK[s];
    if (half_off[s][0]) v[7:0] = NEG_VAL[s][7:0];
    if (half_off[s][1]) v[15:8] = NEG_VAL[s][15:8];
    return v;
  endfunction
  task automatic outw(input int s, input logic [15:0] v);
    logic [15:0] m;
    m = OUT_MASK[s];
    expq.push_back({REG_OUT_LO, v[7:0] & m[7:0], m[7:0]});
    expq.push_back({REG_OUT_HI, v[15:8] & m[15:8], m[15:8]});
  endtask
  task automatic cfg(input int s);
    outw(s, pinv(s));
    expq.push_back({REG_POL_LO, POL_NONE, 8'hff});
    expq.push_back({REG_POL_HI, POL_NONE, 8'hff});
    expq.push_back({REG_DIR_LO, ~OUT_MASK[s][7:0], 8'hff});
    expq.push_back({REG_DIR_HI, ~OUT_MASK[s][15:8], 8'hff});
    addr_we[s] = 1'b1;
    tick(1);
    addr_we[s] = 1'b0;
  endtask
  task automatic drain();
    for (int i = 0; i < 20000 && expq.size() > 0; i++) tick(1);
    chk(16'(expq.size()), 16'h0000);
  endtask
  task automatic wait_state(input logic [15:0] x);
    for (int i = 0; i < 12000 && state !== x; i++) tick(1);
    chk(state, x);
  endtask
  // every write seen by the expander is matched against the oldest note
  always @(posedge wstb) begin
    if (wreg == REG_OUT_LO) t_lo.push_back($time);
    e = expq.size() > 0 ? expq.pop_front() : 24'hffffff;
    chk({wreg, wdat & e[7:0]}, e[23:8]);
  end
  initial begin
    #800_000;
    n_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(85));
    tick(20);
    rst_n = 1'b1;
    core_out[3] = 16'($urandom);
    cfg(3);
    tick(50);
    eeprom_done = 1'b1;
    drain();
    core_out[3] = ~core_out[3];
    outw(3, pinv(3));
    drain();
    chk(16'(t_lo[1] - t_lo[0] >= (UPD - 10) * 10), 16'h0001);
    core_out[0] = 16'($urandom);
    half_off[0] = 2'b10;
    pins = 16'($urandom);
    cfg(0);
    drain();
    wait_state((pinv(0) & 16'hf0f0) | (pins & 16'h0f0f));
    pins = pins ^ 16'h0505;
    wait_state((pinv(0) & 16'hf0f0) | (pins & 16'h0f0f));
    outw(0, pinv(0));
    reload = 1'b1;
    tick(1);
    reload = 1'b0;
    drain();
    // test mode: the written data field, not the core view, goes to the pins
    dwd = pinv(0) ^ (16'($urandom) | 16'h0010); // bit 4 flips so an update is owed
    tm = 1'b1;
    dwe = 1'b1;
    tick(1);
    dwe = 1'b0;
    outw(0, dwd);
    drain();
    // slot one: nobody answers, so no write notes are queued for it
    addr_we[1] = 1'b1;
    tick(1);
    addr_we[1] = 1'b0;
    for (int i = 0; i < 8000 && status[0] !== 1'b1; i++) tick(1);
    chk(16'(status[0]), 16'h0001);
    status_clr = 1'b1;
    tick(1);
    status_clr = 1'b0;
    tick(2);
    chk(16'(status), 16'h0000);
    complete_run();
  end
endmodule
